// ===== tbiu_pkg.sv
package tbiu_pkg;
    // ----------------------------------------------------------------
    // Register map (byte addresses, one aligned word each)
    // ----------------------------------------------------------------
    localparam logic [7:0] TBIU_ADDR_PRESCALE = 8'h00;
    localparam logic [7:0] TBIU_ADDR_TB0_CTRL = 8'h04;
    localparam logic [7:0] TBIU_ADDR_TB1_CTRL = 8'h08;
    localparam logic [7:0] TBIU_ADDR_IRQ_FLAG = 8'h0c;
    localparam logic [7:0] TBIU_ADDR_IRQ_EN   = 8'h10;
    localparam logic [7:0] TBIU_ADDR_CORE     = 8'h14;
    localparam logic [7:0] TBIU_ADDR_STATUS   = 8'h18;
    localparam logic [7:0] TBIU_ADDR_MASK     = 8'h1c;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int TBIU_RUN_BIT      = 7;
    localparam int TBIU_FLAG_TB0     = 0;
    localparam int TBIU_FLAG_TB1     = 1;
    localparam int TBIU_FLAG_LV      = 2;
    localparam int TBIU_CORE_GIE     = 0;
    localparam int TBIU_CORE_SERVICE = 1;
    localparam int TBIU_CORE_RET_IRQ = 2;
    localparam int TBIU_CORE_RET     = 3;
    localparam int TBIU_CORE_SLEEP   = 4;
    localparam int TBIU_CORE_STKFULL = 5;

    // ----------------------------------------------------------------
    // Reset values and encodings
    // ----------------------------------------------------------------
    localparam logic [1:0] TBIU_SRC_SYS    = 2'h0;
    localparam logic [1:0] TBIU_SRC_SYS4   = 2'h1;
    localparam logic [7:0] TBIU_CTRL_RESET = 8'h00;
    localparam logic [2:0] TBIU_FLAG_RESET = 3'h0;
    localparam int         TBIU_PERIOD_MIN_LOG2 = 8;
    localparam int         TBIU_CNT_W      = 15;
    localparam logic [1:0] TBIU_DIV4_LAST  = 2'h3;
    localparam logic [1:0] TBIU_RESP_OKAY  = 2'h0;
    localparam logic [1:0] TBIU_RESP_SLVERR = 2'h2;
endpackage

// ===== tbiu_top.sv
// Design decisions made here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ns
// Functional notes
// - Overflow of each time base sets its own request flag.
// - Vector called only with global enable, source enable, stack not full.
// - Servicing a time base clears its flag and the global enable.
// - Prescaler source: 00 system clock, 01 system/4, 1x sub clock.
// - Bit 7 of each control register runs its time base; resets 0.
// - Time base zero period is 2^(8+code) prescaler clocks.
// - Time base one period is 2^(8+code) prescaler clocks.
// - Unimplemented control and select bits read as zero.
// - Low supply sets low-voltage flag; its vector needs both enables, stack free.
// - Servicing low voltage clears its flag and the global enable.
// - Any request flag rising wakes sleep regardless of enables.
// - Flags stay set until serviced or cleared by software.
// - Taking an interrupt pushes only the program counter.
// - Return-from-interrupt sets global enable; plain return leaves it unchanged.
module tbiu_top
    import tbiu_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        sub_clock,
    input  wire logic        low_voltage_in,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             irq,
    output logic             wake_pulse,
    output logic             vector_call,
    output logic [1:0]       vector_id,
    output logic             pc_push
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Terminal count test for a 2^(8+sel) period
    function automatic logic tbiu_period_hit(input logic [TBIU_CNT_W-1:0] cnt,
                                             input logic [2:0]            sel);
        logic [TBIU_CNT_W-1:0] lim;
        lim = TBIU_CNT_W'((32'h1 << (TBIU_PERIOD_MIN_LOG2 + int'(sel))) - 32'h1);
        tbiu_period_hit = (cnt & lim) == lim;
    endfunction

    // Writable register decode, shared by write response and read response
    function automatic logic tbiu_map_hit(input logic [7:0] a);
        tbiu_map_hit = (a == TBIU_ADDR_PRESCALE) | (a == TBIU_ADDR_TB0_CTRL) |
                       (a == TBIU_ADDR_TB1_CTRL) | (a == TBIU_ADDR_IRQ_FLAG) |
                       (a == TBIU_ADDR_IRQ_EN)   | (a == TBIU_ADDR_CORE) |
                       (a == TBIU_ADDR_MASK);
    endfunction

    typedef enum logic [2:0] {
        TBIU_ST_IDLE  = 3'b001,
        TBIU_ST_WRESP = 3'b010,
        TBIU_ST_RRESP = 3'b100
    } tbiu_state_t;

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    logic [1:0] sub_sync_r;
    logic [1:0] lv_sync_r;
    logic       sub_prev_r;
    logic       lv_prev_r;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            sub_sync_r <= 2'h0;
            lv_sync_r  <= 2'h0;
            sub_prev_r <= 1'b0;
            lv_prev_r  <= 1'b0;
        end else begin
            sub_sync_r <= {sub_sync_r[0], sub_clock};
            lv_sync_r  <= {lv_sync_r[0], low_voltage_in};
            sub_prev_r <= sub_sync_r[1];
            lv_prev_r  <= lv_sync_r[1];
        end
    end

    wire sub_tick = sub_sync_r[1] & ~sub_prev_r;
    wire lv_event = lv_sync_r[1] & ~lv_prev_r;

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [1:0]            prescale_src_sel_r;
    logic                  tick0_run_r;
    logic                  tick1_run_r;
    logic [2:0]            tick0_period_sel_r;
    logic [2:0]            tick1_period_sel_r;
    logic [2:0]            req_flag_r;
    logic [2:0]            irq_en_r;
    logic                  global_irq_enable_r;
    logic                  sleep_r;
    logic                  stack_full_r;
    logic [2:0]            status_r;
    logic [2:0]            mask_r;
    logic [1:0]            div4_r;
    logic [TBIU_CNT_W-1:0] cnt0_r;
    logic [TBIU_CNT_W-1:0] cnt1_r;
    tbiu_state_t           state_r;

    // ----------------------------------------------------------------
    // Prescaler clock enable
    // ----------------------------------------------------------------
    wire prescaler_clock = (prescale_src_sel_r == TBIU_SRC_SYS)  ? 1'b1 :
                           (prescale_src_sel_r == TBIU_SRC_SYS4) ? (div4_r == TBIU_DIV4_LAST) :
                           sub_tick;

    always_ff @(posedge clk) begin
        if (!resetn) div4_r <= 2'h0;
        else         div4_r <= div4_r + 2'h1;
    end

    // ----------------------------------------------------------------
    // Time base counters
    // ----------------------------------------------------------------
    wire tb0_ovf = tick0_run_r & prescaler_clock &
                   tbiu_period_hit(cnt0_r, tick0_period_sel_r);
    wire tb1_ovf = tick1_run_r & prescaler_clock &
                   tbiu_period_hit(cnt1_r, tick1_period_sel_r);

    // Counters hold while stopped; a period change takes effect at once, on the masked running count
    always_ff @(posedge clk) begin
        if (!resetn) begin
            cnt0_r <= '0;
            cnt1_r <= '0;
        end else begin
            if (tick0_run_r && prescaler_clock) cnt0_r <= cnt0_r + 1'b1;
            if (tick1_run_r && prescaler_clock) cnt1_r <= cnt1_r + 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite decode
    // ----------------------------------------------------------------
    wire        is_idle  = (state_r == TBIU_ST_IDLE);
    wire        do_write = is_idle & s_axi_awvalid & s_axi_wvalid;
    wire        do_read  = is_idle & ~do_write & s_axi_arvalid;
    wire        wr_lane0 = do_write & s_axi_wstrb[0];
    wire [7:0]  wbyte    = s_axi_wdata[7:0];
    wire [7:0]  wa       = s_axi_awaddr;
    wire [7:0]  ra       = s_axi_araddr;
    wire        w_psc    = wr_lane0 & (wa == TBIU_ADDR_PRESCALE);
    wire        w_tb0    = wr_lane0 & (wa == TBIU_ADDR_TB0_CTRL);
    wire        w_tb1    = wr_lane0 & (wa == TBIU_ADDR_TB1_CTRL);
    wire        w_flag   = wr_lane0 & (wa == TBIU_ADDR_IRQ_FLAG);
    wire        w_en     = wr_lane0 & (wa == TBIU_ADDR_IRQ_EN);
    wire        w_core   = wr_lane0 & (wa == TBIU_ADDR_CORE);
    wire        w_mask   = wr_lane0 & (wa == TBIU_ADDR_MASK);
    wire        w_hit    = tbiu_map_hit(wa);
    wire        r_status = do_read & (ra == TBIU_ADDR_STATUS);

    // ----------------------------------------------------------------
    // Interrupt arbitration and core sequencing
    // ----------------------------------------------------------------
    wire [2:0] raw_set  = {lv_event, tb1_ovf, tb0_ovf};
    wire [2:0] pending  = req_flag_r & irq_en_r;
    wire       can_take = global_irq_enable_r & ~stack_full_r & (|pending);
    wire       take_req = w_core & wbyte[TBIU_CORE_SERVICE] & can_take;
    // Fixed priority: time base 0, time base 1, low voltage
    wire [1:0] take_id  = pending[TBIU_FLAG_TB0] ? 2'h0 :
                          pending[TBIU_FLAG_TB1] ? 2'h1 : 2'h2;
    wire [2:0] take_clr = take_req ? (3'h1 << take_id) : 3'h0;
    wire [2:0] sw_clr   = w_flag ? ~wbyte[2:0] : 3'h0;
    wire [2:0] sw_set   = w_flag ? wbyte[2:0] : 3'h0;
    // Hardware set beats any clear arriving in the same cycle
    wire [2:0] flag_nxt = (req_flag_r & ~sw_clr & ~take_clr) | sw_set | raw_set;
    wire [2:0] rise     = flag_nxt & ~req_flag_r;
    wire [2:0] st_clr   = r_status ? status_r : 3'h0;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            req_flag_r <= TBIU_FLAG_RESET;
            status_r   <= TBIU_FLAG_RESET;
            irq        <= 1'b0;
        end else begin
            req_flag_r <= flag_nxt;
            status_r   <= (status_r & ~st_clr) | raw_set;
            irq        <= |(((status_r & ~st_clr) | raw_set) & mask_r);
        end
    end

    // A pre-set flag cannot rise again, so it no longer wakes the core
    always_ff @(posedge clk) begin
        if (!resetn) begin
            wake_pulse <= 1'b0;
            sleep_r    <= 1'b0;
        end else begin
            wake_pulse <= sleep_r & (|rise);
            if (sleep_r && (|rise))                         sleep_r <= 1'b0;
            else if (w_core && wbyte[TBIU_CORE_SLEEP])      sleep_r <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            global_irq_enable_r <= 1'b0;
            vector_call         <= 1'b0;
            vector_id           <= 2'h0;
            pc_push             <= 1'b0;
        end else begin
            vector_call <= take_req;
            pc_push     <= take_req;
            if (take_req) vector_id <= take_id;
            if (take_req)                                  global_irq_enable_r <= 1'b0;
            else if (w_core && wbyte[TBIU_CORE_RET_IRQ])   global_irq_enable_r <= 1'b1;
            else if (w_core && !wbyte[TBIU_CORE_RET])
                global_irq_enable_r <= wbyte[TBIU_CORE_GIE];
        end
    end

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!resetn) begin
            prescale_src_sel_r <= TBIU_SRC_SYS;
            tick0_run_r        <= TBIU_CTRL_RESET[TBIU_RUN_BIT];
            tick1_run_r        <= TBIU_CTRL_RESET[TBIU_RUN_BIT];
            tick0_period_sel_r <= TBIU_CTRL_RESET[2:0];
            tick1_period_sel_r <= TBIU_CTRL_RESET[2:0];
            irq_en_r           <= TBIU_FLAG_RESET;
            mask_r             <= TBIU_FLAG_RESET;
            stack_full_r       <= 1'b0;
        end else begin
            if (w_psc) prescale_src_sel_r <= wbyte[1:0];
            if (w_tb0) begin
                tick0_run_r        <= wbyte[TBIU_RUN_BIT];
                tick0_period_sel_r <= wbyte[2:0];
            end
            if (w_tb1) begin
                tick1_run_r        <= wbyte[TBIU_RUN_BIT];
                tick1_period_sel_r <= wbyte[2:0];
            end
            if (w_en)   irq_en_r     <= wbyte[2:0];
            if (w_mask) mask_r       <= wbyte[2:0];
            if (w_core) stack_full_r <= wbyte[TBIU_CORE_STKFULL];
        end
    end

    // ----------------------------------------------------------------
    // Read mux
    // ----------------------------------------------------------------
    wire [7:0] core_rd = {2'h0, stack_full_r, sleep_r, 3'h0, global_irq_enable_r};
    wire       r_hit   = tbiu_map_hit(ra) | (ra == TBIU_ADDR_STATUS);
    wire [7:0] rd_byte =
        (ra == TBIU_ADDR_PRESCALE) ? {6'h00, prescale_src_sel_r} :
        (ra == TBIU_ADDR_TB0_CTRL) ? {tick0_run_r, 4'h0, tick0_period_sel_r} :
        (ra == TBIU_ADDR_TB1_CTRL) ? {tick1_run_r, 4'h0, tick1_period_sel_r} :
        (ra == TBIU_ADDR_IRQ_FLAG) ? {5'h00, req_flag_r} :
        (ra == TBIU_ADDR_IRQ_EN)   ? {5'h00, irq_en_r} :
        (ra == TBIU_ADDR_CORE)     ? core_rd :
        (ra == TBIU_ADDR_STATUS)   ? {5'h00, status_r} :
        (ra == TBIU_ADDR_MASK)     ? {5'h00, mask_r} : 8'h00;

    // ----------------------------------------------------------------
    // AXI4-Lite handshake
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_r       <= TBIU_ST_IDLE;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_arready <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= TBIU_RESP_OKAY;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= TBIU_RESP_OKAY;
        end else begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_arready <= 1'b0;
            case (state_r)
                TBIU_ST_IDLE: begin
                    if (do_write) begin
                        s_axi_awready <= 1'b1;
                        s_axi_wready  <= 1'b1;
                        s_axi_bvalid  <= 1'b1;
                        s_axi_bresp   <= w_hit ? TBIU_RESP_OKAY : TBIU_RESP_SLVERR;
                        state_r       <= TBIU_ST_WRESP;
                    end else if (do_read) begin
                        s_axi_arready <= 1'b1;
                        s_axi_rvalid  <= 1'b1;
                        s_axi_rdata   <= {24'h000000, rd_byte};
                        s_axi_rresp   <= r_hit ? TBIU_RESP_OKAY : TBIU_RESP_SLVERR;
                        state_r       <= TBIU_ST_RRESP;
                    end
                end
                TBIU_ST_WRESP: begin
                    if (s_axi_bready) begin
                        s_axi_bvalid <= 1'b0;
                        state_r      <= TBIU_ST_IDLE;
                    end
                end
                TBIU_ST_RRESP: begin
                    if (s_axi_rready) begin
                        s_axi_rvalid <= 1'b0;
                        state_r      <= TBIU_ST_IDLE;
                    end
                end
                default: begin
                    state_r <= TBIU_ST_IDLE;
                end
            endcase
        end
    end

endmodule // tbiu_top

// ===== tbiu_checker.sv
`timescale 1ns/1ns
module tbiu_checker (
    input wire logic       clk,
    input wire logic       resetn,
    input wire logic       s_axi_awvalid,
    input wire logic       s_axi_awready,
    input wire logic       s_axi_wvalid,
    input wire logic       s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic       s_axi_bvalid,
    input wire logic       s_axi_bready,
    input wire logic       s_axi_arvalid,
    input wire logic       s_axi_arready,
    input wire logic       s_axi_rvalid,
    input wire logic       s_axi_rready,
    input wire logic       irq,
    input wire logic       wake_pulse,
    input wire logic       vector_call,
    input wire logic [1:0] vector_id,
    input wire logic       pc_push
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // ----------------------------------------------------------------
    // Interrupt side
    // ----------------------------------------------------------------
    push_with_call_a: assert property (vector_call == pc_push)
        else $error("program counter push not paired with vector call");
    call_single_a: assert property (vector_call |=> !vector_call)
        else $error("vector call longer than one cycle");
    vector_code_a: assert property (vector_call |-> vector_id != 2'h3)
        else $error("vector call with undefined source code");
    wake_single_a: assert property (wake_pulse |=> !wake_pulse)
        else $error("wake pulse longer than one cycle");
    // ----------------------------------------------------------------
    // Register bus
    // ----------------------------------------------------------------
    write_answer_a: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid
        && !s_axi_rvalid |=> s_axi_awready && s_axi_wready && s_axi_bvalid)
        else $error("idle write not answered next cycle");
    read_answer_a: assert property (s_axi_arvalid && !s_axi_awvalid && !s_axi_bvalid
        && !s_axi_rvalid |=> s_axi_arready && s_axi_rvalid)
        else $error("idle read not answered next cycle");
    bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped before handshake");
    rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("read response dropped before handshake");
    one_response_a: assert property (!(s_axi_bvalid && s_axi_rvalid))
        else $error("write and read responses pending together");
    call_seen_c: cover property (vector_call);
    wake_seen_c: cover property (wake_pulse);
    irq_rise_c: cover property ($rose(irq));
    slverr_c: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule // tbiu_checker

// ===== tb_top.sv
`timescale 1ns/1ns
module tb_top;
    import tbiu_pkg::*;
    logic        clk = 1'b0, resetn = 1'b0, sub_clock = 1'b0, sub_run = 1'b0;
    logic        low_voltage_in = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [3:0]  wstrb = 4'h1;
    logic [31:0] wdata = 32'h0, rdv;
    logic [1:0]  resp, bresp, rresp, vector_id, last_id;
    logic        awready, wready, bvalid, arready, rvalid, irq, wake_pulse, vector_call;
    logic        pc_push;
    logic [31:0] rdata;
    int          fails = 0, compares = 0, vcount = 0, wcount = 0, n;

    tbiu_top u_dut (.clk(clk), .resetn(resetn), .sub_clock(sub_clock),
        .low_voltage_in(low_voltage_in), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq),
        .wake_pulse(wake_pulse), .vector_call(vector_call), .vector_id(vector_id),
        .pc_push(pc_push));

    always #2 clk = ~clk;
    // Sub clock moves only on clk edges by NBA, so the synchroniser never races it
    always @(posedge clk) if (sub_run) sub_clock <= ~sub_clock;
    always @(posedge clk) begin
        if (vector_call && pc_push) begin
            vcount <= vcount + 1;
            last_id <= vector_id;
        end
        if (wake_pulse) wcount <= wcount + 1;
    end

    task automatic results;
        $display("comparisons %0d mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // ----------------------------------------------------------------
    // Bus tasks: each address and data channel released on its own ready
    // ----------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            k++;
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && k < 50);
        resp = bresp;
        bready <= 1'b0;
        if (k >= 50) fails++;
    endtask

    task automatic rd(input logic [7:0] a);
        int k;
        k = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            k++;
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && k < 50);
        rdv = rdata;
        resp = rresp;
        rready <= 1'b0;
        if (k >= 50) fails++;
    endtask

    task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e);
        rd(a);
        chk(nm, rdv & m, e);
    endtask

    task automatic wait_irq(input int bound);
        n = 0;
        while (irq !== 1'b1 && n < bound) begin
            @(posedge clk);
            n++;
        end
    endtask

    // Pre-set core control, then request service and count vector calls
    task automatic svc(input logic [31:0] pre, input logic [31:0] cmd, input int calls,
                       input logic [1:0] id);
        int v0;
        wr(TBIU_ADDR_CORE, pre);
        v0 = vcount;
        wr(TBIU_ADDR_CORE, cmd);
        repeat (3) @(posedge clk);
        chk("vector calls", vcount - v0, calls);
        if (calls > 0) chk("vector id", {30'h0, last_id}, {30'h0, id});
    endtask

    initial begin
        #(4 * 40000);
        fails++;
        results();
    end

    initial begin
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        rc("prescale reset", TBIU_ADDR_PRESCALE, 32'hff, 32'h0);
        rc("tb0 reset", TBIU_ADDR_TB0_CTRL, 32'hff, 32'h0);
        rc("tb1 reset", TBIU_ADDR_TB1_CTRL, 32'hff, 32'h0);
        // Sub clock is stopped, so running both bases here adds no ticks
        wr(TBIU_ADDR_PRESCALE, 32'hff);
        rc("prescale bits", TBIU_ADDR_PRESCALE, 32'hffffffff, 32'h3);
        wr(TBIU_ADDR_TB0_CTRL, 32'hff);
        rc("tb0 bits", TBIU_ADDR_TB0_CTRL, 32'hffffffff, 32'h87);
        wr(TBIU_ADDR_TB1_CTRL, 32'hff);
        rc("tb1 bits", TBIU_ADDR_TB1_CTRL, 32'hffffffff, 32'h87);
        wr(TBIU_ADDR_TB0_CTRL, 32'h0);
        wr(TBIU_ADDR_TB1_CTRL, 32'h0);
        wr(8'h20, 32'h1);
        chk("unmapped write resp", resp, TBIU_RESP_SLVERR);
        rc("unmapped read", 8'h20, 32'hffffffff, 32'h0);
        chk("unmapped read resp", resp, TBIU_RESP_SLVERR);
        // Registers live in byte lane 0; a write without that lane changes nothing
        wstrb <= 4'h2;
        wr(TBIU_ADDR_MASK, 32'h7);
        wstrb <= 4'h1;
        rc("upper lane write", TBIU_ADDR_MASK, 32'hffffffff, 32'h0);
        // Time base zero, system clock, shortest period
        wr(TBIU_ADDR_PRESCALE, 32'h0);
        wr(TBIU_ADDR_MASK, 32'h1);
        wr(TBIU_ADDR_TB0_CTRL, 32'h80);
        wait_irq(400);
        chk("tb0 period", (n >= 250 && n <= 266), 1);
        rc("tb0 flag", TBIU_ADDR_IRQ_FLAG, 32'h1, 32'h1);
        rc("tb0 status", TBIU_ADDR_STATUS, 32'h1, 32'h1);
        repeat (2) @(posedge clk);
        chk("irq after clear", irq, 1'b0);
        wr(TBIU_ADDR_TB0_CTRL, 32'h0);
        wr(TBIU_ADDR_IRQ_FLAG, 32'h0);
        repeat (600) @(posedge clk);
        rc("stopped base", TBIU_ADDR_IRQ_FLAG, 32'h7, 32'h0);
        // Time base one, system clock over four, period code 1
        wr(TBIU_ADDR_PRESCALE, 32'h1);
        wr(TBIU_ADDR_MASK, 32'h2);
        wr(TBIU_ADDR_TB1_CTRL, 32'h81);
        wait_irq(3000);
        chk("tb1 period", (n >= 2040 && n <= 2062), 1);
        rc("tb1 flag", TBIU_ADDR_IRQ_FLAG, 32'h2, 32'h2);
        wr(TBIU_ADDR_TB1_CTRL, 32'h0);
        rd(TBIU_ADDR_STATUS);
        // Sub clock source: no ticks while the pin is still
        wr(TBIU_ADDR_PRESCALE, 32'h2);
        wr(TBIU_ADDR_MASK, 32'h1);
        wr(TBIU_ADDR_TB0_CTRL, 32'h80);
        repeat (1000) @(posedge clk);
        chk("sub source idle", irq, 1'b0);
        sub_run <= 1'b1;
        wait_irq(1500);
        chk("sub source ticks", irq, 1'b1);
        wr(TBIU_ADDR_TB0_CTRL, 32'h0);
        sub_run <= 1'b0;
        rd(TBIU_ADDR_STATUS);
        // Servicing, priority, enables and stack
        wr(TBIU_ADDR_IRQ_FLAG, 32'h7);
        wr(TBIU_ADDR_IRQ_EN, 32'h7);
        svc(32'h1, 32'h3, 1, 2'h0);
        rc("flag after service", TBIU_ADDR_IRQ_FLAG, 32'h7, 32'h6);
        rc("gie after service", TBIU_ADDR_CORE, 32'h1, 32'h0);
        svc(32'h0, 32'h2, 0, 2'h0);
        svc(32'h21, 32'h23, 0, 2'h0);
        svc(32'h1, 32'h3, 1, 2'h1);
        wr(TBIU_ADDR_IRQ_EN, 32'h3);
        svc(32'h1, 32'h3, 0, 2'h0);
        rc("flag kept", TBIU_ADDR_IRQ_FLAG, 32'h7, 32'h4);
        wr(TBIU_ADDR_IRQ_EN, 32'h7);
        svc(32'h1, 32'h3, 1, 2'h2);
        rc("lv flag serviced", TBIU_ADDR_IRQ_FLAG, 32'h7, 32'h0);
        rc("gie after lv", TBIU_ADDR_CORE, 32'h1, 32'h0);
        wr(TBIU_ADDR_CORE, 32'h4);
        rc("return sets gie", TBIU_ADDR_CORE, 32'h1, 32'h1);
        wr(TBIU_ADDR_CORE, 32'h0);
        // Plain return with the enable bit also set must still leave it at zero
        wr(TBIU_ADDR_CORE, 32'h9);
        rc("plain return", TBIU_ADDR_CORE, 32'h1, 32'h0);
        // Low supply, wake from sleep, and blocking by a pre-set flag
        wr(TBIU_ADDR_IRQ_EN, 32'h0);
        wr(TBIU_ADDR_CORE, 32'h10);
        n = wcount;
        low_voltage_in <= 1'b1;
        repeat (10) @(posedge clk);
        chk("wake count", wcount - n, 1);
        rc("lv flag", TBIU_ADDR_IRQ_FLAG, 32'h4, 32'h4);
        rc("lv status", TBIU_ADDR_STATUS, 32'h4, 32'h4);
        rc("sleep cleared", TBIU_ADDR_CORE, 32'h10, 32'h0);
        low_voltage_in <= 1'b0;
        repeat (5) @(posedge clk);
        wr(TBIU_ADDR_IRQ_FLAG, 32'h0);
        wr(TBIU_ADDR_IRQ_FLAG, 32'h4);
        wr(TBIU_ADDR_CORE, 32'h10);
        n = wcount;
        low_voltage_in <= 1'b1;
        repeat (10) @(posedge clk);
        chk("wake blocked", wcount - n, 0);
        results();
    end
endmodule // tb_top

bind tbiu_top tbiu_checker u_chk (.clk(clk), .resetn(resetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq),
    .wake_pulse(wake_pulse), .vector_call(vector_call), .vector_id(vector_id),
    .pc_push(pc_push));
